// ===== aisc_pkg.sv
package aisc_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ             = 10_000_000;
  localparam int unsigned STEP_MS            = 5;
  localparam int unsigned STEP_CYCLES        = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned UPD_DEFAULT_MS     = 150;
  localparam int unsigned FILT_TC_DEFAULT_MS = 1000;
  localparam logic [15:0] UPD_DEFAULT_STEPS  = 16'(UPD_DEFAULT_MS / STEP_MS);
  localparam logic [19:0] TC_DEFAULT_STEPS   = 20'(FILT_TC_DEFAULT_MS / STEP_MS);

  // curve points, values are signed q16.16
  localparam int unsigned NUM_POINTS  = 20;
  localparam int unsigned BASE_POINTS = 2;
  localparam int unsigned PT_IDX_W    = 5;
  localparam logic [31:0] Q_ONE       = 32'h0001_0000;
  localparam logic [31:0] Q_HALF      = 32'h0000_8000;
  localparam logic [31:0] Q_FRAC_MASK = 32'h0000_ffff;
  localparam logic [31:0] PT2_IN_DEFAULT = Q_ONE;
  localparam logic [19:0] BASE_USED_MASK = 20'h0_0003;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_SRC      = 8'h04;
  localparam logic [7:0] REG_UPD      = 8'h08;
  localparam logic [7:0] REG_TC       = 8'h0c;
  localparam logic [7:0] REG_MIN      = 8'h10;
  localparam logic [7:0] REG_MAX      = 8'h14;
  localparam logic [7:0] REG_USED     = 8'h18;
  localparam logic [7:0] REG_STAT     = 8'h1c;
  localparam logic [7:0] REG_INPUT    = 8'h20;
  localparam logic [7:0] REG_OUTPUT   = 8'h24;
  localparam logic [7:0] REG_IRQ_ST   = 8'h28;
  localparam logic [7:0] REG_IRQ_MASK = 8'h2c;
  localparam logic [7:0] PT_BASE      = 8'h40;
  localparam int unsigned PT_OUT_BIT  = 2;
  localparam int unsigned PT_IDX_LSB  = 3;

  // control fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_FILT_BIT = 1;
  localparam int unsigned CTRL_OOR_BIT  = 2;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned SRC_W         = 6;
  localparam logic [SRC_W-1:0] SRC_DEFAULT = 6'h00;

  // scaled value handling
  localparam logic [1:0] MODE_FLOAT   = 2'h0;
  localparam logic [1:0] MODE_FLOOR   = 2'h1;
  localparam logic [1:0] MODE_CEIL    = 2'h2;
  localparam logic [1:0] MODE_NEAREST = 2'h3;

  // interrupt bits
  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned IRQ_OOR  = 0;
  localparam int unsigned IRQ_DONE = 1;
  localparam int unsigned IRQ_LOST = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_EVAL = 4'h4,
    ST_CALC = 4'h8
  } aisc_state_type;
endpackage : aisc_pkg

// ===== aisc_pt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aisc_pt_if;
  logic        wr_en;
  logic [4:0]  wr_idx;
  logic        wr_out;
  logic [31:0] wr_data;
  logic [4:0]  rd_idx;
  logic [31:0] rd_in;
  logic [31:0] rd_out;
  modport ctl (output wr_en, wr_idx, wr_out, wr_data, rd_idx, input rd_in, rd_out);
  modport mem (input wr_en, wr_idx, wr_out, wr_data, rd_idx, output rd_in, rd_out);
endinterface : aisc_pt_if
`default_nettype wire

// ===== aisc_point_mem.sv
`timescale 1ns/1ps
`default_nettype none
module aisc_point_mem
  import aisc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  aisc_pt_if.mem   pt
);
  logic [31:0] in_mem  [NUM_POINTS];
  logic [31:0] out_mem [NUM_POINTS];

  // point table, reset loads the default straight line
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_POINTS; i++) begin
        in_mem[i]  <= (i == 1) ? PT2_IN_DEFAULT : 32'h0000_0000;
        out_mem[i] <= 32'h0000_0000;
      end
    end else if (pt.wr_en) begin
      if (pt.wr_out) begin
        out_mem[pt.wr_idx] <= pt.wr_data;
      end else begin
        in_mem[pt.wr_idx] <= pt.wr_data;
      end
    end
  end

  // registered read, one cycle latency
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pt.rd_in  <= 32'h0000_0000;
      pt.rd_out <= 32'h0000_0000;
    end else begin
      pt.rd_in  <= in_mem[pt.rd_idx];
      pt.rd_out <= out_mem[pt.rd_idx];
    end
  end
endmodule : aisc_point_mem
`default_nettype wire

// ===== aisc_curve.sv
// Summary of operation
// - with filtering on, first-order low-pass averages the input by time constant
// - flag when measured input is below minimum or above maximum
// - the curve drives its own range violation flag as a binary output
// - on signal loss hold last valid measurement, never drop to minimum
// - measurement refreshed once per update cycle, 5 ms steps, default 150 ms
// - points pair input with output; defaults in 0/1, outputs 0
// - default mapping is the straight line through points one and two
// - points three onward individually marked used, up to twenty total
// - filter time constant in 5 ms steps, default 1 s, filter off default
// - range flag only raised when range signalling enabled, default off
// - curve enable gates scaling and measurement, default disabled
// - source select from enumerated input list, default code zero
`timescale 1ns/1ps
`default_nettype none
module aisc_curve
  import aisc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [7:0]         address_i,
  input  wire logic               read_i,
  input  wire logic               write_i,
  input  wire logic [31:0]        writedata_i,
  output logic      [31:0]        readdata_o,
  output logic                    waitrequest_o,
  input  wire logic signed [31:0] sample_i,
  input  wire logic               sample_valid_i,
  input  wire logic               signal_lost_i,
  output logic      [SRC_W-1:0]   src_sel_o,
  output logic                    meas_enable_o,
  output logic signed [31:0]      scaled_o,
  output logic                    scaled_valid_o,
  output logic                    curve_range_violation_flag_o,
  output logic                    irq_o
);

  aisc_pt_if pt ();

  aisc_point_mem u_mem (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pt      (pt.mem)
  );

  // configuration
  logic               filt_en;
  logic               oor_en;
  logic [1:0]         mode;
  logic [15:0]        upd_steps;
  logic [19:0]        tc_steps;
  logic signed [31:0] in_min;
  logic signed [31:0] in_max;
  logic [19:0]        pt_used;
  logic [IRQ_W-1:0]   irq_mask;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   next_irq_status;

  // bus decode
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  pt_off;
  logic [4:0]  pt_idx;
  logic        is_pt;
  logic [31:0] rd_mux;

  // measurement path
  logic [31:0]        cyc_cnt;
  logic [15:0]        upd_cnt;
  logic               step_tick;
  logic               upd_go;
  logic signed [31:0] raw;
  logic signed [31:0] filt;
  logic               have_sample;
  logic               lost_q;
  logic signed [32:0] filt_diff;
  logic signed [32:0] tc_div;
  logic signed [32:0] filt_quot;

  // curve walk
  aisc_state_type     state;
  logic [4:0]         idx;
  logic [1:0]         npts;
  logic signed [31:0] x;
  logic signed [31:0] ax;
  logic signed [31:0] ay;
  logic signed [31:0] bx;
  logic signed [31:0] by;
  logic               pt_is_used;
  logic signed [31:0] interp;
  logic signed [31:0] rounded;
  logic               next_oor;
  logic signed [63:0] prod;
  logic signed [63:0] den;

  // slave accepts on the edge where waitrequest is sampled low
  assign wr_acc = write_i && !waitrequest_o;
  assign rd_acc = read_i && !waitrequest_o;
  assign pt_off = address_i - PT_BASE;
  assign pt_idx = pt_off[7:PT_IDX_LSB];
  assign is_pt  = (address_i >= PT_BASE) && (pt_idx < 5'(NUM_POINTS));

  // point table writes go straight into the memory
  assign pt.wr_en   = wr_acc && is_pt;
  assign pt.wr_idx  = pt_idx;
  assign pt.wr_out  = address_i[PT_OUT_BIT];
  assign pt.wr_data = writedata_i;
  assign pt.rd_idx  = idx;

  // one wait state on every access, idle waitrequest high
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !(waitrequest_o && (read_i || write_i));
    end
  end

  // read mux; the point table is write only to keep its read port free
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_i)
      REG_CTRL:     rd_mux = {26'h0, mode, 1'b0, oor_en, filt_en, meas_enable_o};
      REG_SRC:      rd_mux = {26'h0, src_sel_o};
      REG_UPD:      rd_mux = {16'h0, upd_steps};
      REG_TC:       rd_mux = {12'h0, tc_steps};
      REG_MIN:      rd_mux = in_min;
      REG_MAX:      rd_mux = in_max;
      REG_USED:     rd_mux = {12'h0, pt_used | BASE_USED_MASK};
      REG_STAT:     rd_mux = {28'h0, lost_q, have_sample, curve_range_violation_flag_o,
                              (state != ST_IDLE)};
      REG_INPUT:    rd_mux = filt;
      REG_OUTPUT:   rd_mux = scaled_o;
      REG_IRQ_ST:   rd_mux = {29'h0, irq_status};
      REG_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // read data loaded during the wait state, stands at the taking edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && waitrequest_o) begin
      readdata_o <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meas_enable_o <= 1'b0;
      filt_en       <= 1'b0;
      oor_en        <= 1'b0;
      mode          <= MODE_FLOAT;
      src_sel_o     <= SRC_DEFAULT;
      upd_steps     <= UPD_DEFAULT_STEPS;
      tc_steps      <= TC_DEFAULT_STEPS;
      in_min        <= 32'sh0000_0000;
      in_max        <= 32'sh0000_0000;
      pt_used       <= 20'h0_0000;
      irq_mask      <= '0;
    end else if (wr_acc) begin
      case (address_i)
        REG_CTRL: begin
          meas_enable_o <= writedata_i[CTRL_EN_BIT];
          filt_en       <= writedata_i[CTRL_FILT_BIT];
          oor_en        <= writedata_i[CTRL_OOR_BIT];
          mode          <= writedata_i[CTRL_MODE_LSB +: 2];
        end
        REG_SRC:      src_sel_o <= writedata_i[SRC_W-1:0];
        REG_UPD:      upd_steps <= writedata_i[15:0];
        REG_TC:       tc_steps  <= writedata_i[19:0];
        REG_MIN:      in_min    <= writedata_i;
        REG_MAX:      in_max    <= writedata_i;
        REG_USED:     pt_used   <= writedata_i[19:0];
        REG_IRQ_MASK: irq_mask  <= writedata_i[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // 5 ms step base and update cycle, both cleared to zero while the curve is off
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !meas_enable_o) begin
      cyc_cnt   <= 32'h0000_0000;
      upd_cnt   <= 16'h0000;
      step_tick <= 1'b0;
      upd_go    <= 1'b0;
    end else begin
      step_tick <= 1'b0;
      upd_go    <= 1'b0;
      if (cyc_cnt == 32'(STEP_CYCLES_P - 1)) begin
        cyc_cnt   <= 32'h0000_0000;
        step_tick <= 1'b1;
        // zero steps behaves as one step
        if (upd_cnt + 16'h0001 >= upd_steps) begin
          upd_cnt <= 16'h0000;
          upd_go  <= 1'b1;
        end else begin
          upd_cnt <= upd_cnt + 16'h0001;
        end
      end else begin
        cyc_cnt <= cyc_cnt + 32'h0000_0001;
      end
    end
  end

  // sample capture; a lost signal leaves the last valid value in place
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      raw         <= 32'sh0000_0000;
      have_sample <= 1'b0;
      lost_q      <= 1'b0;
    end else begin
      lost_q <= signal_lost_i;
      if (meas_enable_o && sample_valid_i && !signal_lost_i) begin
        raw         <= sample_i;
        have_sample <= 1'b1;
      end
    end
  end

  // filter step: y += (x - y) * 5 ms / tc
  assign filt_diff = 33'(raw) - 33'(filt);
  assign tc_div    = (tc_steps == 20'h0_0000) ? 33'sh0_0000_0001 : {13'h0, tc_steps};
  assign filt_quot = filt_diff / tc_div;

  // filter frozen too while lost, so the hold really is the last value
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      filt <= 32'sh0000_0000;
    end else if (step_tick && !signal_lost_i) begin
      if (filt_en) begin
        filt <= filt + filt_quot[31:0];
      end else begin
        filt <= raw;
      end
    end
  end

  // point 1 and 2 are always part of the curve
  assign pt_is_used = pt_used[idx] || (idx < 5'(BASE_POINTS));

  // linear interpolation over the chosen segment
  always_comb begin
    prod   = 64'(x - ax) * 64'(by - ay);
    den    = 64'(bx - ax);
    interp = ay;
    if (den != 64'sh0) begin
      interp = ay + 32'(prod / den);
    end
  end

  // result handling on q16.16
  always_comb begin
    rounded = interp;
    case (mode)
      MODE_FLOOR:   rounded = interp & ~Q_FRAC_MASK;
      MODE_CEIL:    rounded = (interp + Q_FRAC_MASK) & ~Q_FRAC_MASK;
      MODE_NEAREST: rounded = (interp + Q_HALF) & ~Q_FRAC_MASK;
      default:      rounded = interp;
    endcase
  end

  // range check against the limits, only when signalling is on
  assign next_oor = oor_en && ((x < in_min) || (x > in_max));

  // walk the point table; points are taken in ascending index order
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      idx   <= 5'h00;
      npts  <= 2'h0;
      x     <= 32'sh0000_0000;
      ax    <= 32'sh0000_0000;
      ay    <= 32'sh0000_0000;
      bx    <= 32'sh0000_0000;
      by    <= 32'sh0000_0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (upd_go) begin
            x     <= filt;
            idx   <= 5'h00;
            npts  <= 2'h0;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          state <= ST_EVAL;
        end
        ST_EVAL: begin
          if (pt_is_used) begin
            ax <= bx;
            ay <= by;
            bx <= pt.rd_in;
            by <= pt.rd_out;
            if (npts != 2'h2) begin
              npts <= npts + 2'h1;
            end
          end
          // beyond the last point the last segment is extended
          if ((pt_is_used && npts != 2'h0 && x <= $signed(pt.rd_in))
              || idx == 5'(NUM_POINTS - 1)) begin
            state <= ST_CALC;
          end else begin
            idx   <= idx + 5'h01;
            state <= ST_READ;
          end
        end
        ST_CALC: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // publish result and flag at the end of each update
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scaled_o                     <= 32'sh0000_0000;
      scaled_valid_o               <= 1'b0;
      curve_range_violation_flag_o <= 1'b0;
    end else begin
      scaled_valid_o <= 1'b0;
      if (!meas_enable_o) begin
        curve_range_violation_flag_o <= 1'b0;
      end else if (state == ST_CALC) begin
        scaled_o                     <= rounded;
        scaled_valid_o               <= 1'b1;
        curve_range_violation_flag_o <= next_oor;
      end
    end
  end

  // sticky events; a read clears only the bits it returned, a new event wins
  always_comb begin
    next_irq_status = irq_status;
    if (rd_acc && address_i == REG_IRQ_ST) begin
      next_irq_status = irq_status & ~readdata_o[IRQ_W-1:0];
    end
    if (state == ST_CALC && next_oor && !curve_range_violation_flag_o) begin
      next_irq_status[IRQ_OOR] = 1'b1;
    end
    if (state == ST_CALC) begin
      next_irq_status[IRQ_DONE] = 1'b1;
    end
    if (signal_lost_i && !lost_q) begin
      next_irq_status[IRQ_LOST] = 1'b1;
    end
  end

  // interrupt level follows the masked status one cycle later
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_status <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_o      <= |(irq_status & irq_mask);
    end
  end

endmodule : aisc_curve
`default_nettype wire

// ===== aisc_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module aisc_front_end
  import aisc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               enable_i,
  input  wire logic [SRC_W-1:0]   src_sel_i,
  input  wire logic signed [31:0] value_i,
  input  wire logic               lost_i,
  output logic signed [31:0]      sample_o,
  output logic                    sample_valid_o,
  output logic                    lost_o
);
  logic [1:0] div;
  // conversion every fourth cycle; a lost line keeps strobing scrambled data,
  // so only the curve's own loss handling can keep the held value
  always_ff @(posedge clk_i) begin
    div <= enable_i ? div + 2'h1 : 2'h0;
    lost_o <= lost_i;
    sample_valid_o <= enable_i && div == 2'h0 && src_sel_i < 6'h2a;
    sample_o <= lost_i ? ~sample_o : value_i;
  end
endmodule : aisc_front_end
`default_nettype wire

// ===== aisc_curve_sva.sv
`timescale 1ns/1ps
`default_nettype none
module aisc_curve_sva
  import aisc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES_P = STEP_CYCLES
) (
  input wire logic               clk_i,
  input wire logic               rst_b_i,
  input wire logic               read_i,
  input wire logic               write_i,
  input wire logic               waitrequest_o,
  input wire logic [SRC_W-1:0]   src_sel_o,
  input wire logic               meas_enable_o,
  input wire logic signed [31:0] scaled_o,
  input wire logic               scaled_valid_o,
  input wire logic               curve_range_violation_flag_o,
  input wire logic               irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // bus answers after exactly one wait state
  property p_wait_one;
    (read_i || write_i) && waitrequest_o |=> !waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus request not answered");
  property p_wait_short;
    !waitrequest_o |=> waitrequest_o;
  endproperty
  a_wait_short: assert property (p_wait_short) else $error("waitrequest low too long");
  // source code only moves on an accepted write
  property p_src_write;
    $changed(src_sel_o) |-> !$past(waitrequest_o) && $past(write_i);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source changed without write");
  property p_valid_pulse;
    scaled_valid_o |=> !scaled_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid longer than a cycle");
  // output holds between updates
  property p_out_hold;
    $changed(scaled_o) |-> scaled_valid_o;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output moved off update");
  property p_flag_upd;
    $changed(curve_range_violation_flag_o) && meas_enable_o |-> scaled_valid_o;
  endproperty
  a_flag_upd: assert property (p_flag_upd) else $error("flag moved off update");
  property p_flag_off;
    !meas_enable_o [*3] |-> !curve_range_violation_flag_o;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag set while disabled");
  // irq only drops after a register access
  property p_irq_fall;
    $fell(irq_o) |-> !$past(waitrequest_o) || !$past(waitrequest_o, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without access");
endmodule : aisc_curve_sva
bind aisc_curve aisc_curve_sva #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_sva (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .src_sel_o(src_sel_o), .meas_enable_o(meas_enable_o),
  .scaled_o(scaled_o), .scaled_valid_o(scaled_valid_o),
  .curve_range_violation_flag_o(curve_range_violation_flag_o), .irq_o(irq_o));
`default_nettype wire

// ===== aisc_curve_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module aisc_curve_tb_top;
  import aisc_pkg::*;
  logic               clk_i;
  logic               rst_b_i;
  logic [7:0]         address_i;
  logic               read_i;
  logic               write_i;
  logic [31:0]        writedata_i;
  logic [31:0]        readdata_o;
  logic               waitrequest_o;
  logic signed [31:0] sample_i;
  logic               sample_valid_i;
  logic               signal_lost_i;
  logic [SRC_W-1:0]   src_sel_o;
  logic               meas_enable_o;
  logic signed [31:0] scaled_o;
  logic               scaled_valid_o;
  logic               flag;
  logic               irq_o;
  logic signed [31:0] value;
  logic               lost;
  logic [31:0]        rd_v;
  int                 gap;
  int                 miscompares;
  int                 checks_done;
  int                 cycles;
  // 10-cycle step; with REG_UPD at 2 each update takes 20 cycles
  aisc_curve #(.STEP_CYCLES_P(10)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .sample_i(sample_i), .sample_valid_i(sample_valid_i),
    .signal_lost_i(signal_lost_i), .src_sel_o(src_sel_o), .meas_enable_o(meas_enable_o),
    .scaled_o(scaled_o), .scaled_valid_o(scaled_valid_o),
    .curve_range_violation_flag_o(flag), .irq_o(irq_o));
  aisc_front_end u_fe (
    .clk_i(clk_i), .enable_i(meas_enable_o), .src_sel_i(src_sel_o), .value_i(value),
    .lost_i(lost), .sample_o(sample_i), .sample_valid_o(sample_valid_i),
    .lost_o(signal_lost_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    rd_v = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask : bus
  // wait for k updates; gap keeps the spacing of the last one
  task automatic upd(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (scaled_valid_o !== 1'b1 && n < 3000);
      gap = n;
      chk(32'(n < 3000), 32'h1);
    end
  endtask : upd
  task automatic t_defaults;
    logic [7:0] ra [6];
    logic [31:0] re [6];
    ra = '{REG_UPD, REG_TC, REG_USED, REG_CTRL, REG_SRC, 8'h30};
    re = '{32'h1e, 32'hc8, 32'h3, 32'h0, 32'h0, 32'h0};
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd_v, re[i]);
    end
    bus(1'b1, REG_SRC, 32'h3);
    @(posedge clk_i);
    chk(32'(src_sel_o), 32'h3);
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_curve;
    logic [31:0] ex [4];
    ex = '{32'hf000, 32'h0, 32'h10000, 32'h10000};
    value <= 32'sh8000;
    bus(1'b1, REG_UPD, 32'h2);
    bus(1'b1, REG_CTRL, 32'h1);
    upd(3);
    chk(32'(gap), 32'd20);
    chk(scaled_o, 32'h0);
    bus(1'b1, 8'h4c, 32'h40000);
    upd(2);
    chk(scaled_o, 32'h20000);
    value <= 32'sh5000;
    bus(1'b1, 8'h4c, 32'h30000);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, REG_CTRL, (32'(m) << 4) | 32'h1);
      upd(2);
      chk(scaled_o, ex[m]);
    end
    // third point bends the line: 2.0 maps to 5.0, not 6.0
    value <= 32'sh20000;
    bus(1'b1, 8'h50, 32'h30000);
    bus(1'b1, 8'h54, 32'h70000);
    bus(1'b1, REG_USED, 32'h7);
    bus(1'b1, REG_CTRL, 32'h1);
    upd(2);
    chk(scaled_o, 32'h50000);
    $display("test curve done");
  endtask : t_curve
  task automatic t_range;
    bus(1'b1, REG_MAX, 32'h28000);
    bus(1'b1, REG_CTRL, 32'h5);
    upd(2);
    chk(32'(flag), 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    value <= 32'sh30000;
    upd(2);
    chk(32'(flag), 32'h1);
    @(posedge clk_i);
    chk(32'(irq_o), 32'h1);
    bus(1'b0, REG_IRQ_ST, 32'h0);
    chk(32'(rd_v[IRQ_OOR]), 32'h1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    value <= -32'sh10000;
    upd(2);
    chk(32'(flag), 32'h1);
    bus(1'b1, REG_CTRL, 32'h1);
    upd(2);
    chk(32'(flag), 32'h0);
    $display("test range done");
  endtask : t_range
  task automatic t_filter;
    value <= 32'sh0;
    upd(2);
    value <= 32'sh20000;
    bus(1'b1, REG_CTRL, 32'h3);
    upd(2);
    chk(32'(scaled_o > 0 && scaled_o < 32'sh50000), 32'h1);
    bus(1'b1, REG_TC, 32'h1);
    upd(2);
    chk(scaled_o, 32'h50000);
    $display("test filter done");
  endtask : t_filter
  task automatic t_lost;
    bus(1'b1, REG_CTRL, 32'h1);
    upd(2);
    lost <= 1'b1;
    value <= 32'sh0;
    upd(3);
    chk(scaled_o, 32'h50000);
    lost <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(32'(meas_enable_o), 32'h0);
    // as long as three update cycles: a disabled curve publishes nothing
    repeat (60) begin
      @(posedge clk_i);
      chk(32'(scaled_valid_o), 32'h0);
    end
    $display("test lost done");
  endtask : t_lost
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // a hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    address_i = 8'h0;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h0;
    value = 32'sh0;
    lost = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_defaults();
    t_curve();
    t_range();
    t_filter();
    t_lost();
    final_report();
  end
endmodule : aisc_curve_tb_top
`default_nettype wire
